/* hw/fsc_pkg.sv */
// Constants shared by the configuration fuse store
package fsc_pkg;

  // Request space selector
  localparam logic SPACE_FUSE = 1'b0;
  localparam logic SPACE_IDENT = 1'b1;

  // Fuse byte selector, one code per separately addressable byte
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // Identification space word addresses
  localparam logic [1:0] IDENT_ADDR_0 = 2'h0;
  localparam logic [1:0] IDENT_ADDR_1 = 2'h1;
  localparam logic [1:0] IDENT_ADDR_2 = 2'h2;

  // Extended byte fields
  localparam int EXT_BROWNOUT_LSB = 0;
  localparam int EXT_BROWNOUT_MSB = 2;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hf8;

  // High byte fields
  localparam int HIGH_DEBUG_BIT = 7;
  localparam int HIGH_SCAN_BIT = 6;
  localparam int HIGH_SERIAL_DL_BIT = 5;
  localparam int HIGH_WDOG_BIT = 4;
  localparam int HIGH_KEEP_NV_BIT = 3;
  localparam int HIGH_BOOT_LSB = 1;
  localparam int HIGH_BOOT_MSB = 2;
  localparam int HIGH_RST_VEC_BIT = 0;

  // Low byte fields
  localparam int LOW_DIV8_BIT = 7;
  localparam int LOW_CLKOUT_BIT = 6;
  localparam int LOW_SUT_LSB = 4;
  localparam int LOW_SUT_MSB = 5;
  localparam int LOW_CKSRC_LSB = 0;
  localparam int LOW_CKSRC_MSB = 3;

  // Reset (shipping) values; 0 means programmed
  localparam logic [7:0] EXT_RESET = 8'hff;
  localparam logic [7:0] HIGH_RESET = 8'h99;
  localparam logic [7:0] LOW_RESET = 8'h62;

  // Clock source code for the internal RC oscillator at 8 MHz
  localparam logic [3:0] CKSRC_RC_8MHZ = 4'h2;

  // Identification bytes and calibration byte; values are arbitrary
  localparam logic [7:0] IDENT_BYTE_0 = 8'h5a;
  localparam logic [7:0] IDENT_BYTE_1 = 8'h3c;
  localparam logic [7:0] IDENT_BYTE_2 = 8'h71;
  localparam logic [7:0] OSC_TRIM_STORED = 8'h80;

  // Page geometry
  localparam int FLASH_WORD_BITS = 7;
  localparam int FLASH_PAGE_BITS = 10;
  localparam int PROGRAM_COUNTER_TOP_BIT = 16;
  localparam int NV_BYTE_BITS = 3;
  localparam int NV_PAGE_BITS = 9;
  localparam int NVDATA_ADDRESS_TOP_BIT = 11;

endpackage

/* hw/fsc_page_split.sv */
// Splits flash and data memory addresses into page and in-page index
`timescale 1ns/1ns
module fsc_page_split
  import fsc_pkg::*;
(
  // Clock and control
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Addresses to split
  input wire logic [PROGRAM_COUNTER_TOP_BIT:0] pc_i,
  input wire logic [NVDATA_ADDRESS_TOP_BIT:0] nvdata_byte_address_i,
  // Split results
  output logic [FLASH_WORD_BITS-1:0] word_in_page_index_o,
  output logic [FLASH_PAGE_BITS-1:0] flash_page_index_o,
  output logic [NV_BYTE_BITS-1:0] nv_byte_in_page_o,
  output logic [NV_PAGE_BITS-1:0] nv_page_index_o
);

  wire logic [FLASH_WORD_BITS-1:0] next_word = pc_i[FLASH_WORD_BITS-1:0];
  wire logic [FLASH_PAGE_BITS-1:0] next_page = pc_i[PROGRAM_COUNTER_TOP_BIT:FLASH_WORD_BITS];
  wire logic [NV_BYTE_BITS-1:0] next_nv_byte = nvdata_byte_address_i[NV_BYTE_BITS-1:0];
  wire logic [NV_PAGE_BITS-1:0] next_nv_page = nvdata_byte_address_i[NVDATA_ADDRESS_TOP_BIT:NV_BYTE_BITS];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      word_in_page_index_o <= '0;
      flash_page_index_o <= '0;
      nv_byte_in_page_o <= '0;
      nv_page_index_o <= '0;
    end else if (ce_i) begin
      word_in_page_index_o <= next_word;
      flash_page_index_o <= next_page;
      nv_byte_in_page_o <= next_nv_byte;
      nv_page_index_o <= next_nv_page;
    end
  end

endmodule // fsc_page_split

/* hw/fsc_fuse_store.sv */
// Fuse store: three fuse bytes, latching, identification space, page split
`timescale 1ns/1ns
module fsc_fuse_store
  import fsc_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Mode pins from the programmer, asynchronous
  input wire logic prog_mode_pin_i,
  input wire logic serial_mode_pin_i,
  // Lock state, same clock, 0 means programmed
  input wire logic memory_lock_first_i,
  // Programmer request port, same clock
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_space_i,
  input wire logic [1:0] req_addr_i,
  input wire logic req_hi_i,
  input wire logic [7:0] req_wdata_i,
  output logic req_ack_o,
  output logic req_refused_o,
  output logic [7:0] req_rdata_o,
  // Chip erase
  input wire logic erase_i,
  output logic erase_flash_o,
  output logic erase_nvdata_o,
  output logic erase_lock_o,
  // Latched configuration to consumers; keep-data also follows the stored byte
  output logic [2:0] brownout_level_o,
  output logic debug_port_enable_o,
  output logic boundary_scan_port_enable_o,
  output logic serial_download_enable_o,
  output logic watchdog_forced_on_o,
  output logic keep_nvdata_on_erase_o,
  output logic [1:0] boot_size_o,
  output logic reset_vector_select_o,
  output logic clock_divide_by_eight_o,
  output logic clock_pin_output_o,
  output logic [1:0] startup_time_o,
  output logic [3:0] clock_source_o,
  output logic osc_rc_8mhz_o,
  // Oscillator trim
  output logic [7:0] osc_trim_register_o,
  // Clock output pin
  input wire logic sys_clk_i,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_n_o,
  // Page geometry
  input wire logic [PROGRAM_COUNTER_TOP_BIT:0] pc_i,
  input wire logic [NVDATA_ADDRESS_TOP_BIT:0] nvdata_byte_address_i,
  output logic [FLASH_WORD_BITS-1:0] word_in_page_index_o,
  output logic [FLASH_PAGE_BITS-1:0] flash_page_index_o,
  output logic [NV_BYTE_BITS-1:0] nv_byte_in_page_o,
  output logic [NV_PAGE_BITS-1:0] nv_page_index_o
);

  typedef enum logic [1:0] {
    FSC_POWERUP,
    FSC_NORMAL,
    FSC_PROG
  } fsc_mode_t;

  // Stored fuse bytes, 0 = programmed
  logic [7:0] ext_config_byte;
  logic [7:0] high_config_byte;
  logic [7:0] low_config_byte;
  // Latched copies handed to consumers
  logic [7:0] lat_ext;
  logic [7:0] lat_high;
  logic [7:0] lat_low;
  // Pin synchronisers
  logic prog_meta;
  logic prog_sync;
  logic serial_meta;
  logic serial_sync;
  fsc_mode_t mode;
  fsc_mode_t next_mode;

  // Read view of one fuse byte, hiding the serial-download fuse in serial mode
  function automatic logic [7:0] fuse_view(input logic [1:0] sel, input logic [7:0] e,
                                           input logic [7:0] h, input logic [7:0] l,
                                           input logic ser);
    logic [7:0] v;
    v = 8'hff;
    unique case (sel)
      SEL_LOW: v = l;
      SEL_HIGH: begin
        v = h;
        if (ser) begin
          v[HIGH_SERIAL_DL_BIT] = 1'b1;
        end
      end
      SEL_EXT: v = e | EXT_UNUSED_MASK;
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  // Request decoding
  // Fuse access needs programming mode; identification reads at addresses 0 to 2 are allowed in any mode
  wire logic in_prog = (mode == FSC_PROG);
  wire logic sel_valid = (req_addr_i != 2'h3);
  wire logic fuse_req = req_valid_i && (req_space_i == SPACE_FUSE);
  wire logic ident_req = req_valid_i && (req_space_i == SPACE_IDENT);
  // Lock input is active low; a programmed first lock bit freezes the fuses
  wire logic lock_set = !memory_lock_first_i;
  wire logic fuse_wr_ok = fuse_req && req_write_i && in_prog && sel_valid && !lock_set;
  wire logic fuse_rd_ok = fuse_req && !req_write_i && in_prog && sel_valid;
  wire logic ident_rd_ok = ident_req && !req_write_i && sel_valid;
  wire logic req_ok = fuse_wr_ok || fuse_rd_ok || ident_rd_ok;

  // Write data merged per byte
  // In serial mode the stored serial-download bit is kept, so a programmer
  // cannot cut off its own access path
  wire logic [7:0] next_ext = req_wdata_i | EXT_UNUSED_MASK;
  wire logic [7:0] next_high = {req_wdata_i[7:6],
                                serial_sync ? high_config_byte[HIGH_SERIAL_DL_BIT] : req_wdata_i[5],
                                req_wdata_i[4:0]};
  wire logic [7:0] next_low = req_wdata_i;

  // Identification read data
  wire logic [7:0] ident_lo = (req_addr_i == IDENT_ADDR_0) ? IDENT_BYTE_0 :
                              (req_addr_i == IDENT_ADDR_1) ? IDENT_BYTE_1 : IDENT_BYTE_2;
  wire logic [7:0] ident_hi = (req_addr_i == IDENT_ADDR_0) ? OSC_TRIM_STORED : 8'hff;
  wire logic [7:0] ident_data = req_hi_i ? ident_hi : ident_lo;
  wire logic [7:0] fuse_data = fuse_view(req_addr_i, ext_config_byte, high_config_byte,
                                         low_config_byte, serial_sync);
  wire logic [7:0] next_rdata = (req_space_i == SPACE_IDENT) ? ident_data : fuse_data;

  // Latch events: power-up, programming entry and programming exit
  wire logic enter_prog = (mode == FSC_NORMAL) && prog_sync;
  wire logic leave_prog = in_prog && !prog_sync;
  wire logic do_latch = (mode == FSC_POWERUP) || enter_prog || leave_prog;

  // Keep-data acts at once from the stored byte, otherwise from the latch
  wire logic keep_nv_eff = lat_high[HIGH_KEEP_NV_BIT] & high_config_byte[HIGH_KEEP_NV_BIT];

  // Mode sequencing
  // Any illegal state code falls back to power-up, which relatches everything
  always_comb begin
    next_mode = mode;
    unique case (mode)
      FSC_POWERUP: next_mode = prog_sync ? FSC_PROG : FSC_NORMAL;
      FSC_NORMAL: next_mode = prog_sync ? FSC_PROG : FSC_NORMAL;
      FSC_PROG: next_mode = prog_sync ? FSC_PROG : FSC_NORMAL;
      default: next_mode = FSC_POWERUP;
    endcase
  end

  // Two-stage pin synchronisers; only the second stage is read by logic
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prog_meta <= 1'b0;
      prog_sync <= 1'b0;
      serial_meta <= 1'b0;
      serial_sync <= 1'b0;
    end else if (ce_i) begin
      prog_meta <= prog_mode_pin_i;
      prog_sync <= prog_meta;
      serial_meta <= serial_mode_pin_i;
      serial_sync <= serial_meta;
    end
  end

  // Power-up state lasts one enabled edge and triggers the first latch
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode <= FSC_POWERUP;
    end else if (ce_i) begin
      mode <= next_mode;
    end
  end

  // Stored fuse bytes; chip erase has no path in here
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ext_config_byte <= EXT_RESET;
      high_config_byte <= HIGH_RESET;
      low_config_byte <= LOW_RESET;
    end else if (ce_i && fuse_wr_ok) begin
      unique case (req_addr_i)
        SEL_EXT: ext_config_byte <= next_ext;
        SEL_HIGH: high_config_byte <= next_high;
        SEL_LOW: low_config_byte <= next_low;
        default: ;
      endcase
    end
  end

  // Latched copies move only on the three latch events, never on a write,
  // so a fuse write in programming mode disturbs no running consumer except keep-data
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lat_ext <= EXT_RESET;
      lat_high <= HIGH_RESET;
      lat_low <= LOW_RESET;
    end else if (ce_i && do_latch) begin
      lat_ext <= ext_config_byte;
      lat_high <= high_config_byte;
      lat_low <= low_config_byte;
    end
  end

  // Request answer, one cycle after the request
  // Read data holds until the next accepted read; refusals leave it alone
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      req_ack_o <= 1'b0;
      req_refused_o <= 1'b0;
      req_rdata_o <= 8'hff;
    end else if (ce_i) begin
      req_ack_o <= req_valid_i && req_ok;
      req_refused_o <= req_valid_i && !req_ok;
      if (fuse_rd_ok || ident_rd_ok) begin
        req_rdata_o <= next_rdata;
      end
    end
  end

  // Erase strobes to the memory controllers
  // The data-memory strobe is withheld while keep-data is in effect
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      erase_flash_o <= 1'b0;
      erase_nvdata_o <= 1'b0;
      erase_lock_o <= 1'b0;
    end else if (ce_i) begin
      erase_flash_o <= erase_i && in_prog;
      erase_lock_o <= erase_i && in_prog;
      erase_nvdata_o <= erase_i && in_prog && keep_nv_eff;
    end
  end

  // Trim register loaded with the calibration byte while reset is held
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      osc_trim_register_o <= OSC_TRIM_STORED;
    end
  end

  // Consumers see latched values, except keep-data, which also follows the stored byte
  // Enables are active high, so the active-low fuse bits are inverted here
  always_comb begin
    brownout_level_o = lat_ext[EXT_BROWNOUT_MSB:EXT_BROWNOUT_LSB];
    debug_port_enable_o = !lat_high[HIGH_DEBUG_BIT];
    boundary_scan_port_enable_o = !lat_high[HIGH_SCAN_BIT];
    serial_download_enable_o = !lat_high[HIGH_SERIAL_DL_BIT];
    watchdog_forced_on_o = !lat_high[HIGH_WDOG_BIT];
    keep_nvdata_on_erase_o = !keep_nv_eff;
    boot_size_o = lat_high[HIGH_BOOT_MSB:HIGH_BOOT_LSB];
    reset_vector_select_o = lat_high[HIGH_RST_VEC_BIT];
    clock_divide_by_eight_o = !lat_low[LOW_DIV8_BIT];
    clock_pin_output_o = !lat_low[LOW_CLKOUT_BIT];
    startup_time_o = lat_low[LOW_SUT_MSB:LOW_SUT_LSB];
    clock_source_o = lat_low[LOW_CKSRC_MSB:LOW_CKSRC_LSB];
    osc_rc_8mhz_o = (lat_low[LOW_CKSRC_MSB:LOW_CKSRC_LSB] == CKSRC_RC_8MHZ);
  end

  // System clock out on the pin when the fuse is programmed
  assign clock_out_pin_o = sys_clk_i & !lat_low[LOW_CLKOUT_BIT];
  assign clock_out_pin_oe_n_o = lat_low[LOW_CLKOUT_BIT];

  // Page split is registered, one cycle behind its address inputs
  fsc_page_split u_page_split (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pc_i(pc_i),
    .nvdata_byte_address_i(nvdata_byte_address_i),
    .word_in_page_index_o(word_in_page_index_o),
    .flash_page_index_o(flash_page_index_o),
    .nv_byte_in_page_o(nv_byte_in_page_o),
    .nv_page_index_o(nv_page_index_o)
  );

endmodule // fsc_fuse_store

/* tb/fsc_fuse_store_chk.sv */
// Concurrent checks on the fuse store ports
`timescale 1ns/1ns
module fsc_fuse_store_chk
  import fsc_pkg::*;
(
  // Clock and control
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Request port
  input wire logic memory_lock_first_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_space_i,
  input wire logic [1:0] req_addr_i,
  input wire logic req_ack_o,
  input wire logic req_refused_o,
  input wire logic [7:0] req_rdata_o,
  // Erase and configuration
  input wire logic erase_flash_o,
  input wire logic erase_lock_o,
  input wire logic erase_nvdata_o,
  input wire logic keep_nvdata_on_erase_o,
  input wire logic [3:0] clock_source_o,
  input wire logic osc_rc_8mhz_o,
  input wire logic [7:0] osc_trim_register_o,
  // Clock pin
  input wire logic sys_clk_i,
  input wire logic clock_pin_output_o,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe_n_o,
  // Page split
  input wire logic [PROGRAM_COUNTER_TOP_BIT:0] pc_i,
  input wire logic [NVDATA_ADDRESS_TOP_BIT:0] nvdata_byte_address_i,
  input wire logic [FLASH_WORD_BITS-1:0] word_in_page_index_o,
  input wire logic [FLASH_PAGE_BITS-1:0] flash_page_index_o,
  input wire logic [NV_BYTE_BITS-1:0] nv_byte_in_page_o,
  input wire logic [NV_PAGE_BITS-1:0] nv_page_index_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic take = req_valid_i && ce_i;
  property p_answer; take |=> req_ack_o != req_refused_o; endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");
  property p_ident_wr; take && req_write_i && req_space_i |=> req_refused_o; endproperty
  a_ident_wr: assert property (p_ident_wr) else $error("ident write accepted");
  property p_locked; take && req_write_i && !req_space_i && !memory_lock_first_i |=> req_refused_o; endproperty
  a_locked: assert property (p_locked) else $error("fuse write accepted while locked");
  property p_ext_unused;
    take && !req_write_i && !req_space_i && req_addr_i == SEL_EXT |=> !req_ack_o || req_rdata_o[7:3] == 5'h1f;
  endproperty
  a_ext_unused: assert property (p_ext_unused) else $error("unused ext bits not one");
  property p_erase; erase_flash_o |-> erase_lock_o && erase_nvdata_o == !$past(keep_nvdata_on_erase_o); endproperty
  a_erase: assert property (p_erase) else $error("erase strobes wrong");
  property p_trim; osc_trim_register_o == OSC_TRIM_STORED; endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");
  property p_rc8; osc_rc_8mhz_o == (clock_source_o == CKSRC_RC_8MHZ); endproperty
  a_rc8: assert property (p_rc8) else $error("rc flag wrong");
  property p_clkpin; clock_pin_output_o |-> !clock_out_pin_oe_n_o && clock_out_pin_o == sys_clk_i; endproperty
  a_clkpin: assert property (p_clkpin) else $error("clock pin not driven");
  property p_flash_split;
    ce_i && rst_n_i |=> word_in_page_index_o == $past(pc_i[6:0]) && flash_page_index_o == $past(pc_i[16:7]);
  endproperty
  a_flash_split: assert property (p_flash_split) else $error("flash split wrong");
  property p_nv_split;
    ce_i && rst_n_i |=> nv_byte_in_page_o == $past(nvdata_byte_address_i[2:0]) &&
      nv_page_index_o == $past(nvdata_byte_address_i[11:3]);
  endproperty
  a_nv_split: assert property (p_nv_split) else $error("data split wrong");
  c_erase: cover property (erase_flash_o);
  c_refused: cover property (req_refused_o);
  c_clkpin: cover property (clock_pin_output_o && sys_clk_i);
endmodule // fsc_fuse_store_chk

/* tb/fsc_prog_model.sv */
// Programmer model driving the request and erase ports
`timescale 1ns/1ns
module fsc_prog_model (
  // Clock
  input wire logic mclk_i,
  // Request and erase
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_space_o,
  output logic [1:0] req_addr_o,
  output logic req_hi_o,
  output logic [7:0] req_wdata_o,
  output logic erase_o
);
  initial begin
    {req_valid_o, req_write_o, req_space_o, req_addr_o, req_hi_o, req_wdata_o, erase_o} = '0;
  end
  // One-cycle strobe; lines not held show the inverse afterwards
  task send(input logic w, input logic s, input logic [1:0] a, input logic hi, input logic [7:0] d);
    @(posedge mclk_i);
    {req_valid_o, req_write_o, req_space_o, req_addr_o, req_hi_o, req_wdata_o} <= {1'b1, w, s, a, hi, d};
    @(posedge mclk_i);
    {req_valid_o, req_write_o, req_space_o, req_addr_o, req_hi_o, req_wdata_o} <= {1'b0, ~w, ~s, ~a, ~hi, ~d};
  endtask
  task erase();
    @(posedge mclk_i);
    erase_o <= 1'b1;
    @(posedge mclk_i);
    erase_o <= 1'b0;
  endtask
endmodule // fsc_prog_model

/* tb/tb.sv */
// Self-checking bench for the fuse store
`timescale 1ns/1ns
module tb;
  import fsc_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, ce_i = 1, prog_mode_pin_i = 0, serial_mode_pin_i = 0, memory_lock_first_i = 1;
  logic req_valid_i, req_write_i, req_space_i, req_hi_i, erase_i, sys_clk_i = 0;
  logic [1:0] req_addr_i, boot_size_o, startup_time_o;
  logic [7:0] req_wdata_i, req_rdata_o, osc_trim_register_o;
  logic [PROGRAM_COUNTER_TOP_BIT:0] pc_i = '0;
  logic [NVDATA_ADDRESS_TOP_BIT:0] nvdata_byte_address_i = '0;
  logic req_ack_o, req_refused_o, erase_flash_o, erase_nvdata_o, erase_lock_o, debug_port_enable_o;
  logic boundary_scan_port_enable_o, serial_download_enable_o, watchdog_forced_on_o, keep_nvdata_on_erase_o;
  logic reset_vector_select_o, clock_divide_by_eight_o, clock_pin_output_o, osc_rc_8mhz_o;
  logic clock_out_pin_o, clock_out_pin_oe_n_o;
  logic [2:0] brownout_level_o;
  logic [3:0] clock_source_o;
  logic [FLASH_WORD_BITS-1:0] word_in_page_index_o;
  logic [FLASH_PAGE_BITS-1:0] flash_page_index_o;
  logic [NV_BYTE_BITS-1:0] nv_byte_in_page_o;
  logic [NV_PAGE_BITS-1:0] nv_page_index_o;
  logic [31:0] seed = 32'd84189;
  logic [9:0] notes[$];
  logic [9:0] n;
  logic [7:0] e, h, l, hs;
  logic [7:0] idv[3] = '{IDENT_BYTE_0, IDENT_BYTE_1, IDENT_BYTE_2};
  int errors = 0, check_count = 0;
  wire logic [18:0] cfg_now = {brownout_level_o, debug_port_enable_o, boundary_scan_port_enable_o,
    serial_download_enable_o, watchdog_forced_on_o, keep_nvdata_on_erase_o, boot_size_o, reset_vector_select_o,
    clock_divide_by_eight_o, clock_pin_output_o, startup_time_o, clock_source_o};

  fsc_fuse_store u_fsc_fuse_store (.*);
  fsc_prog_model u_fsc_prog_model (.mclk_i(mclk_i), .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_space_o(req_space_i), .req_addr_o(req_addr_i), .req_hi_o(req_hi_i), .req_wdata_o(req_wdata_i),
    .erase_o(erase_i));

  always #25 mclk_i = ~mclk_i;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Active-high consumer view of the three stored bytes
  function automatic logic [18:0] cfg(logic [7:0] fe, logic [7:0] fh, logic [7:0] fl);
    return {fe[2:0], ~fh[7:3], fh[2:1], fh[0], ~fl[7:6], fl[5:0]};
  endfunction
  task chk(input logic [18:0] got, input logic [18:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rq(input logic w, input logic s, input logic [1:0] a, input logic hi, input logic [7:0] d,
          input logic rf, input logic [7:0] rx);
    notes.push_back({~w, rf, rx});
    u_fsc_prog_model.send(w, s, a, hi, d);
  endtask
  task mode(input logic p, input logic s);
    @(posedge mclk_i);
    prog_mode_pin_i <= p;
    serial_mode_pin_i <= s;
    repeat (4) @(posedge mclk_i);
  endtask
  task finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    pc_i <= 17'(rnd());
    nvdata_byte_address_i <= 12'(rnd());
    sys_clk_i <= 1'(rnd());
  end
  always @(negedge mclk_i) begin
    if (req_ack_o === 1'b1 || req_refused_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        n = notes.pop_front();
        chk(req_refused_o, n[8]);
        if (n[9] && !n[8]) chk(req_rdata_o, n[7:0]);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(cfg_now, cfg(EXT_RESET, HIGH_RESET, LOW_RESET));
    rq(0, SPACE_FUSE, SEL_LOW, 0, 8'h00, 1, 8'h00);
    mode(1, 0);
    rq(0, SPACE_FUSE, SEL_EXT, 0, 8'h00, 0, EXT_RESET);
    rq(0, SPACE_FUSE, SEL_HIGH, 0, 8'h00, 0, HIGH_RESET);
    rq(0, SPACE_FUSE, SEL_LOW, 0, 8'h00, 0, LOW_RESET);
    rq(1, SPACE_FUSE, 2'h3, 0, 8'h00, 1, 8'h00);
    e = 8'(rnd());
    h = 8'(rnd()) | 8'h08;
    l = 8'(rnd()) & 8'hbf;
    rq(1, SPACE_FUSE, SEL_EXT, 0, e, 0, 8'h00);
    rq(1, SPACE_FUSE, SEL_HIGH, 0, h, 0, 8'h00);
    rq(1, SPACE_FUSE, SEL_LOW, 0, l, 0, 8'h00);
    rq(0, SPACE_FUSE, SEL_EXT, 0, 8'h00, 0, e | EXT_UNUSED_MASK);
    @(negedge mclk_i);
    chk(cfg_now, cfg(EXT_RESET, HIGH_RESET, LOW_RESET));
    u_fsc_prog_model.erase();
    @(negedge mclk_i);
    chk({erase_flash_o, erase_lock_o, erase_nvdata_o}, 3'b111);
    h = h & 8'hf7;
    rq(1, SPACE_FUSE, SEL_HIGH, 0, h, 0, 8'h00);
    @(negedge mclk_i);
    chk(keep_nvdata_on_erase_o, 1'b1);
    u_fsc_prog_model.erase();
    @(negedge mclk_i);
    chk({erase_flash_o, erase_lock_o, erase_nvdata_o}, 3'b110);
    rq(0, SPACE_FUSE, SEL_HIGH, 0, 8'h00, 0, h);
    rq(0, SPACE_FUSE, SEL_LOW, 0, 8'h00, 0, l);
    rq(0, SPACE_FUSE, SEL_EXT, 0, 8'h00, 0, e | EXT_UNUSED_MASK);
    mode(1, 1);
    rq(0, SPACE_FUSE, SEL_HIGH, 0, 8'h00, 0, h | 8'h20);
    hs = 8'(rnd()) & 8'hf7;
    rq(1, SPACE_FUSE, SEL_HIGH, 0, hs, 0, 8'h00);
    h = {hs[7:6], h[5], hs[4:0]};
    mode(1, 0);
    rq(0, SPACE_FUSE, SEL_HIGH, 0, 8'h00, 0, h);
    mode(0, 0);
    @(negedge mclk_i);
    chk(cfg_now, cfg(e | EXT_UNUSED_MASK, h, l));
    @(posedge mclk_i);
    memory_lock_first_i <= 1'b0;
    mode(1, 0);
    rq(1, SPACE_FUSE, SEL_LOW, 0, 8'h00, 1, 8'h00);
    rq(0, SPACE_FUSE, SEL_LOW, 0, 8'h00, 0, l);
    for (int i = 0; i < 3; i++) rq(0, SPACE_IDENT, 2'(i), 0, 8'h00, 0, idv[i]);
    rq(0, SPACE_IDENT, IDENT_ADDR_0, 1, 8'h00, 0, OSC_TRIM_STORED);
    rq(1, SPACE_IDENT, IDENT_ADDR_1, 0, 8'h00, 1, 8'h00);
    rq(0, SPACE_IDENT, 2'h3, 0, 8'h00, 1, 8'h00);
    for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge mclk_i);
    if (notes.size() != 0) errors++;
    finish_test();
  end
endmodule // tb

bind fsc_fuse_store fsc_fuse_store_chk u_fsc_fuse_store_chk (.mclk_i, .rst_n_i, .ce_i, .memory_lock_first_i,
  .req_valid_i, .req_write_i, .req_space_i, .req_addr_i, .req_ack_o, .req_refused_o, .req_rdata_o,
  .erase_flash_o, .erase_lock_o, .erase_nvdata_o, .keep_nvdata_on_erase_o, .clock_source_o, .osc_rc_8mhz_o,
  .osc_trim_register_o, .sys_clk_i, .clock_pin_output_o, .clock_out_pin_o, .clock_out_pin_oe_n_o, .pc_i,
  .nvdata_byte_address_i, .word_in_page_index_o, .flash_page_index_o, .nv_byte_in_page_o, .nv_page_index_o);
